/* pkg/gpc_pkg.sv */
// Constants for the two-port GPIO block with change interrupt
package gpc_pkg;
  localparam logic [3:0] ADDR_PA_DATA = 4'h0;
  localparam logic [3:0] ADDR_PA_DIR = 4'h1;
  localparam logic [3:0] ADDR_ANALOG = 4'h2;
  localparam logic [3:0] ADDR_PB_DATA = 4'h3;
  localparam logic [3:0] ADDR_PB_DIR = 4'h4;
  localparam logic [3:0] ADDR_OPTION = 4'h5;
  localparam logic [3:0] ADDR_INT_STAT = 4'h6;
  localparam logic [3:0] ADDR_INT_MASK = 4'h7;
  localparam logic [4:0] PA_DIR_RST = 5'h1F;
  localparam logic [7:0] PB_DIR_RST = 8'hFF;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [2:0] ANALOG_RST = 3'h0;
  localparam logic [2:0] ALL_DIGITAL = 3'h6;
  localparam int PULLUP_DIS_BIT = 7;
  localparam int CHANGE_FLAG_BIT = 0;
  localparam int WATCH_LO = 4;
  localparam int STAT_W = 1;
endpackage

/* hdl/gpc_sync.sv */
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module gpc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,               // Core clock
  input wire logic [WIDTH-1:0] async_i, // Raw pin levels
  output logic [WIDTH-1:0] sync_o       // Synchronised levels
);
  logic [WIDTH-1:0] meta_q;

  // First stage only feeds second
  always_ff @(posedge clk_i) begin
    meta_q <= async_i;
    sync_o <= meta_q;
  end
endmodule

/* hdl/gpc_top.sv */
// Two GPIO ports on Wishbone; pull-ups and change interrupt on the second port only
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module gpc_top #(
  parameter int PA_W = 5,
  parameter int PB_W = 8
) (
  input wire logic clk_i,               // Core clock, 40 MHz
  input wire logic rst_i,               // Sync reset, active high
  input wire logic por_i,               // Power-on reset qualifier
  input wire logic [3:0] wb_adr_i,      // Word address
  input wire logic [31:0] wb_dat_i,     // Write data
  input wire logic wb_we_i,             // Write enable
  input wire logic [3:0] wb_sel_i,      // Byte selects
  input wire logic wb_cyc_i,            // Bus cycle
  input wire logic wb_stb_i,            // Strobe
  output logic [31:0] wb_dat_o,         // Read data
  output logic wb_ack_o,                // Acknowledge
  input wire logic [PA_W-1:0] pa_i,     // First port pin levels
  output logic [PA_W-1:0] pa_o,         // First port drive value
  output logic [PA_W-1:0] pa_oe_o,      // First port drive enable
  input wire logic [PB_W-1:0] pb_i,     // Second port pin levels
  output logic [PB_W-1:0] pb_o,         // Second port drive value
  output logic [PB_W-1:0] pb_oe_o,      // Second port drive enable
  output logic [PB_W-1:0] pb_pullup_o,  // Weak pull-up enables
  input wire logic [PB_W-1:0] ovr_en_i, // Peripheral override enable
  input wire logic [PB_W-1:0] ovr_out_i,// Override: one forces output
  input wire logic sleep_i,             // Core is in sleep
  output logic wake_o,                  // Wake request
  output logic irq_o                    // Level interrupt
);
  logic [PA_W-1:0] pa_lat_q;
  logic [PA_W-1:0] pa_dir_q;
  logic [2:0] analog_q;
  logic [PB_W-1:0] pb_lat_q;
  logic [PB_W-1:0] pb_dir_q;
  logic [7:0] option_q;
  logic [gpc_pkg::STAT_W-1:0] stat_q;
  logic [gpc_pkg::STAT_W-1:0] mask_q;
  logic [PB_W-1:0] ref_q;
  logic [PA_W-1:0] pa_s;
  logic [PB_W-1:0] pb_s;
  logic [PB_W-1:0] pb_dir_eff;
  logic [PA_W-1:0] pa_rd;
  logic [PB_W-1:0] mismatch;
  logic change;
  logic acc;
  logic wr;
  logic rd;
  logic pb_read;
  logic flag_clr;
  logic [31:0] rd_d;

  // Pins come from outside the clock domain
  gpc_sync #(.WIDTH(PA_W)) u_sync_a (
    .clk_i(clk_i),
    .async_i(pa_i),
    .sync_o(pa_s)
  );
  gpc_sync #(.WIDTH(PB_W)) u_sync_b (
    .clk_i(clk_i),
    .async_i(pb_i),
    .sync_o(pb_s)
  );

  // One access per strobe; ack low between cycles
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd = acc && !wb_we_i;
  assign pb_read = rd && (wb_adr_i == gpc_pkg::ADDR_PB_DATA);
  assign flag_clr = wr && (wb_adr_i == gpc_pkg::ADDR_INT_STAT);

  // Peripheral overrides direction while enabled
  always_comb begin
    for (int i = 0; i < PB_W; i++) begin
      if (ovr_en_i[i]) begin
        pb_dir_eff[i] = !ovr_out_i[i];
      end else begin
        pb_dir_eff[i] = pb_dir_q[i];
      end
    end
  end

  // All four low pins read as zero unless analog config is all-digital
  always_comb begin
    pa_rd = pa_s;
    if (analog_q != gpc_pkg::ALL_DIGITAL) begin
      pa_rd[3:0] = 4'h0;
    end
  end

  // Watched pins that are inputs and differ from reference
  genvar g;
  generate
    for (g = 0; g < PB_W; g++) begin : g_watch
      if (g >= gpc_pkg::WATCH_LO) begin : g_on
        assign mismatch[g] = pb_dir_eff[g] && (pb_s[g] != ref_q[g]);
      end else begin : g_off
        assign mismatch[g] = 1'b0;
      end
    end
  endgenerate
  assign change = |mismatch;

  // Bus ack, one cycle after strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // Read mux, registered with the ack
  always_comb begin
    rd_d = 32'h0;
    case (wb_adr_i)
      gpc_pkg::ADDR_PA_DATA: rd_d[PA_W-1:0] = pa_rd;
      gpc_pkg::ADDR_PA_DIR: rd_d[PA_W-1:0] = pa_dir_q;
      gpc_pkg::ADDR_ANALOG: rd_d[2:0] = analog_q;
      gpc_pkg::ADDR_PB_DATA: rd_d[PB_W-1:0] = pb_s;
      gpc_pkg::ADDR_PB_DIR: rd_d[PB_W-1:0] = pb_dir_eff;
      gpc_pkg::ADDR_OPTION: rd_d[7:0] = option_q;
      gpc_pkg::ADDR_INT_STAT: rd_d[gpc_pkg::STAT_W-1:0] = stat_q;
      gpc_pkg::ADDR_INT_MASK: rd_d[gpc_pkg::STAT_W-1:0] = mask_q;
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (rd) begin
      wb_dat_o <= rd_d;
    end
  end

  // Output latches survive warm resets, cleared only at power-on
  always_ff @(posedge clk_i) begin
    if (rst_i && por_i) begin
      pa_lat_q <= '0;
      pb_lat_q <= '0;
    end else if (!rst_i && wr) begin
      if (wb_adr_i == gpc_pkg::ADDR_PA_DATA) begin
        pa_lat_q <= wb_dat_i[PA_W-1:0];
      end
      if (wb_adr_i == gpc_pkg::ADDR_PB_DATA) begin
        pb_lat_q <= wb_dat_i[PB_W-1:0];
      end
    end
  end

  // Direction, option and analog configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_dir_q <= gpc_pkg::PA_DIR_RST;
      pb_dir_q <= gpc_pkg::PB_DIR_RST;
      option_q <= gpc_pkg::OPTION_RST;
      analog_q <= gpc_pkg::ANALOG_RST;
    end else if (wr) begin
      case (wb_adr_i)
        gpc_pkg::ADDR_PA_DIR: pa_dir_q <= wb_dat_i[PA_W-1:0];
        gpc_pkg::ADDR_PB_DIR: pb_dir_q <= wb_dat_i[PB_W-1:0];
        gpc_pkg::ADDR_OPTION: option_q <= wb_dat_i[7:0];
        gpc_pkg::ADDR_ANALOG: analog_q <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // Reference recaptured on each second-port data read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= '0;
    end else if (pb_read) begin
      ref_q <= pb_s;
    end
  end

  // Sticky flag; a set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      if (change) begin
        stat_q[gpc_pkg::CHANGE_FLAG_BIT] <= 1'b1;
      end else if (flag_clr && wb_dat_i[gpc_pkg::CHANGE_FLAG_BIT]) begin
        stat_q[gpc_pkg::CHANGE_FLAG_BIT] <= 1'b0;
      end
      if (wr && wb_adr_i == gpc_pkg::ADDR_INT_MASK) begin
        mask_q <= wb_dat_i[gpc_pkg::STAT_W-1:0];
      end
    end
  end

  // Interrupt and wake outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      irq_o <= |(stat_q & mask_q);
      wake_o <= sleep_i && |(stat_q & mask_q);
    end
  end

  // Pin drivers and pull-ups
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_o <= '0;
      pa_oe_o <= '0;
      pb_o <= '0;
      pb_oe_o <= '0;
      pb_pullup_o <= '0;
    end else begin
      pa_o <= pa_lat_q;
      pa_oe_o <= ~pa_dir_q;
      pb_o <= pb_lat_q;
      pb_oe_o <= ~pb_dir_eff;
      for (int i = 0; i < PB_W; i++) begin
        pb_pullup_o[i] <= !option_q[gpc_pkg::PULLUP_DIS_BIT]
          && pb_dir_eff[i];
      end
    end
  end
endmodule

/* bench/gpc_chk.sv */
// Port checker for the two-port GPIO block
`timescale 1ns/10ps
module gpc_chk #(
  parameter int PB_W = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [3:0] wb_adr_i, // Address
  input wire logic wb_we_i, // Write
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [PB_W-1:0] pb_oe_o, // Drive enables
  input wire logic [PB_W-1:0] pb_pullup_o, // Pull-ups
  input wire logic [PB_W-1:0] ovr_en_i, // Override on
  input wire logic [PB_W-1:0] ovr_out_i, // Override dir
  input wire logic sleep_i, // Sleep
  input wire logic wake_o // Wake
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request still waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("request not answered");
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmap_zero: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i[3]) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
    else $error("wake outside sleep");
  a_pull_out: assert property ((pb_pullup_o & pb_oe_o) == '0)
    else $error("pull-up on driven pin");
  a_force_out: assert property (
    $stable(ovr_en_i & ovr_out_i) [*3]
    |-> (ovr_en_i & ovr_out_i & ~pb_oe_o) == '0)
    else $error("override output not driven");
  a_force_in: assert property (
    $stable(ovr_en_i & ~ovr_out_i) [*3]
    |-> (ovr_en_i & ~ovr_out_i & pb_oe_o) == '0)
    else $error("override input driven");
endmodule

/* bench/gpc_pins.sv */
// Board-side pin model: device drive, board drive, pull-up, float
`timescale 1ns/10ps
module gpc_pins #(
  parameter int W = 8
) (
  input wire logic clk_i, // Clock
  input wire logic [W-1:0] dev_i, // Device drive value
  input wire logic [W-1:0] oe_i, // Device drive enable
  input wire logic [W-1:0] pull_i, // Weak pull-up on
  input wire logic [W-1:0] ext_i, // Board level
  input wire logic [W-1:0] ext_en_i, // Board drives
  output logic [W-1:0] pin_o // Resolved level
);
  logic [W-1:0] flt_q = '0;
  // Undriven pins wander so a stale value never reads as valid
  always_ff @(posedge clk_i) begin
    flt_q <= ~flt_q;
  end
  // Device drive wins, then board, then pull-up
  always_comb begin
    pin_o = (oe_i & dev_i) | (~oe_i & ext_en_i & ext_i)
      | (~oe_i & ~ext_en_i & (pull_i | flt_q));
  end
endmodule

/* bench/tb.sv */
// Testbench for the two-port GPIO block
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, we = 1'b0, cyc = 1'b0;
  logic ack, wake, irq, sleep = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wd = 32'h0, dat, r;
  logic [4:0] pa_i, pa_o, pa_oe;
  logic [7:0] pb_i, pb_o, pb_oe, pull, ext = 8'h3C, oen = 8'h00, oout = 8'h00;
  logic [7:0] ext_en = 8'hFF;
  int bad_count = 0, total_checks = 0, n = 0;
  gpc_top gpc_top_i (.clk_i(clk), .rst_i(rst), .por_i(por), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(dat), .wb_ack_o(ack), .pa_i(pa_i), .pa_o(pa_o),
    .pa_oe_o(pa_oe), .pb_i(pb_i), .pb_o(pb_o), .pb_oe_o(pb_oe),
    .pb_pullup_o(pull), .ovr_en_i(oen), .ovr_out_i(oout), .sleep_i(sleep),
    .wake_o(wake), .irq_o(irq));
  gpc_pins #(.W(8)) pb_pins (.clk_i(clk), .dev_i(pb_o), .oe_i(pb_oe),
    .pull_i(pull), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pb_i));
  gpc_pins #(.W(5)) pa_pins (.clk_i(clk), .dev_i(pa_o), .oe_i(pa_oe),
    .pull_i(5'h00), .ext_i(5'h15), .ext_en_i(5'h1F), .pin_o(pa_i));
  // Clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    n++;
    if (n == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic check(input string s, input logic [31:0] v, e);
    total_checks++;
    if (v !== e) begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", s, e, v);
    end
  endtask
  // Classic cycle: hold until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s = 4'hF);
    @(posedge clk);
    adr <= a;
    sel <= s;
    we <= w;
    wd <= d;
    cyc <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    r = dat;
    cyc <= 1'b0;
  endtask
  task automatic do_reset(input logic p);
    por <= p;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic t_reset();
    wb(4'h4, 0, 0); check("pb_dir", r, 32'hFF);
    wb(4'h5, 0, 0); check("option", r, 32'hFF);
    wb(4'h1, 0, 0); check("pa_dir", r, 32'h1F);
    wb(4'h0, 0, 0); check("pa_read", r, 32'h10);
    check("pullups", pull, 32'h0);
    wb(4'h5, 1, 32'h0, 4'hE); wb(4'h5, 0, 0); check("sel_off", r, 32'hFF);
    wb(4'hC, 1, 32'hFF); wb(4'hC, 0, 0); check("unmapped", r, 32'h0);
  endtask
  task automatic t_dir();
    wb(4'h3, 1, 32'hA5); wb(4'h4, 1, 32'h0F); wait_n(3);
    check("pb_oe", pb_oe, 32'hF0);
    check("pb_drive", pb_o & pb_oe, 32'hA0);
    wb(4'h3, 0, 0); check("pb_read", r, 32'hAC);
    wb(4'h5, 1, 32'h0); wait_n(2); check("pull", pull, 32'h0F);
    // Board lets go of the low pins; two reads in opposite float phases
    ext_en <= 8'hF0; wait_n(3); wb(4'h3, 0, 0); check("pulled", r, 32'hAF);
    wait_n(2); wb(4'h3, 0, 0); check("pulled2", r, 32'hAF);
    ext_en <= 8'hFF;
    wb(4'h4, 1, 32'hFF);
  endtask
  task automatic t_change();
    ext <= 8'h00; wait_n(3); wb(4'h3, 0, 0); wb(4'h7, 1, 1); wb(4'h6, 1, 1);
    ext <= 8'h0F; wait_n(5); wb(4'h6, 0, 0); check("low_pins", r, 0);
    ext <= 8'h2F; wait_n(5); wb(4'h6, 0, 0); check("flag", r, 1);
    check("irq", irq, 1);
    wb(4'h6, 1, 1); wb(4'h6, 0, 0); check("flag_held", r, 1);
    wb(4'h3, 0, 0); wb(4'h6, 1, 1); wb(4'h6, 0, 0); check("clr", r, 0);
    check("irq_clr", irq, 0);
    sleep <= 1'b1; ext <= 8'h0F; wait_n(5); check("wake", wake, 1);
    // Let the driven low level settle so the reference bit is zero
    sleep <= 1'b0; wb(4'h4, 1, 32'h7F); wb(4'h3, 1, 0); wait_n(3);
    wb(4'h3, 0, 0);
    wb(4'h6, 1, 1); wb(4'h3, 1, 32'h80); wait_n(5);
    wb(4'h6, 0, 0); check("out_pin", r, 0);
  endtask
  task automatic t_ovr();
    wb(4'h4, 1, 0); oen <= 8'h03; oout <= 8'h01; wait_n(4);
    check("ovr_oe", pb_oe, 32'hFD);
    wb(4'h4, 0, 0); check("ovr_dir", r, 32'h02);
    oen <= 8'h00;
  endtask
  task automatic t_warm();
    wb(4'h0, 1, 32'h1B); do_reset(1'b0); wb(4'h1, 1, 0); wait_n(2);
    check("pa_kept", pa_o, 32'h1B);
    do_reset(1'b1); wb(4'h1, 1, 0); wait_n(2); check("pa_por", pa_o, 0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    t_reset();
    t_dir();
    t_change();
    t_ovr();
    t_warm();
    final_report();
  end
endmodule
bind gpc_top gpc_chk #(.PB_W(PB_W)) gpc_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o), .ovr_en_i(ovr_en_i),
  .ovr_out_i(ovr_out_i), .sleep_i(sleep_i), .wake_o(wake_o));
